// >>> common/pfr_pkg.sv
// Package for the protect and function register block
package pfr_pkg;
  localparam logic [3:0] PFR_ADDR_FUNC = 4'h0;
  localparam logic [3:0] PFR_ADDR_PROT = 4'h4;
  localparam logic [3:0] PFR_ADDR_CMD = 4'h8;
  localparam logic [3:0] PFR_ADDR_STAT = 4'hC;
  localparam int PFR_BIT_RSTDIS = 0;
  localparam int PFR_BIT_AREA = 1;
  localparam int PFR_BIT_PROGRAM_PAUSED_FLAG = 2;
  localparam int PFR_BIT_ERASE_PAUSED_FLAG = 3;
  localparam int PFR_BIT_INFO_ROW_LOCK_0 = 4;
  localparam logic [7:0] PFR_OTP_MASK = 8'hF3;
  localparam logic [7:0] PFR_FUNC_RESET = 8'h00;
  localparam logic [3:0] PFR_PROT_RESET = 4'h0;
  localparam int PFR_NUM_BLOCKS = 128;
  localparam int PFR_BLK_W = 7;
  localparam int PFR_CMD_PGM_START = 0;
  localparam int PFR_CMD_ERS_START = 1;
  localparam int PFR_CMD_SUSPEND = 2;
  localparam int PFR_CMD_RESUME = 3;
  localparam int PFR_CMD_DONE = 4;
  localparam int PFR_CMD_CHIP_ERASE = 5;
  localparam int PFR_CMD_INFO_PGM = 6;
  typedef enum logic [1:0] {PFR_OP_NONE, PFR_OP_PGM, PFR_OP_ERS} pfr_op_e;
endpackage

// >>> hdl/pfr_top.sv
// Protect area decode and function register with an APB slave
//
// Register access over APB and the placing of the registers were decided locally.
`timescale 1ns/100ps
module pfr_top
  import pfr_pkg::*;
#(
  parameter logic RSTDIS_DEFAULT = 1'h0
) (
  input wire logic I_MCLK,
  input wire logic I_RESET_N,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [31:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  output logic [31:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  input wire logic [6:0] I_TARGET_BLOCK,
  input wire logic [1:0] I_TARGET_ROW,
  output logic O_RESTART_DEDICATED_EN,
  output logic O_RESTART_SHARED_EN,
  output logic O_OP_PGM_ACTIVE,
  output logic O_OP_ERS_ACTIVE,
  output logic O_CMD_REJECTED
);
  logic [7:0] func_reg;
  logic [3:0] prot_reg;
  logic rst_done_reg;
  pfr_op_e op_reg;
  logic susp_reg;
  logic rej_reg;
  logic [31:0] rdata_reg;
  logic wr_en;
  logic rd_en;
  logic addr_ok;
  logic [7:0] func_next;
  logic [PFR_NUM_BLOCKS-1:0] prot_map;
  logic blk_prot;
  logic [7:0] cmd;
  logic pgm_ok;
  logic ers_ok;
  logic info_ok;
  logic chip_ok;
  logic [7:0] prot_span;

  assign addr_ok = (I_PADDR[3:0] == PFR_ADDR_FUNC) || (I_PADDR[3:0] == PFR_ADDR_PROT) ||
                   (I_PADDR[3:0] == PFR_ADDR_CMD) || (I_PADDR[3:0] == PFR_ADDR_STAT);
  assign wr_en = I_PSEL && I_PENABLE && I_PWRITE && addr_ok && (I_PADDR[31:4] == 28'h0);
  assign rd_en = I_PSEL && !I_PWRITE;
  assign O_PREADY = 1'h1;
  assign O_PSLVERR = I_PSEL && I_PENABLE && (!addr_ok || (I_PADDR[31:4] != 28'h0));
  assign cmd = (wr_en && I_PADDR[3:0] == PFR_ADDR_CMD) ? I_PWDATA[7:0] : 8'h00;

  // Blocks covered by a low protect code
  always_comb begin
    unique case (prot_reg[2:0])
      3'h0: prot_span = 8'h00;
      3'h1: prot_span = 8'h01;
      3'h2: prot_span = 8'h02;
      3'h3: prot_span = 8'h04;
      3'h4: prot_span = 8'h08;
      3'h5: prot_span = 8'h10;
      3'h6: prot_span = 8'h20;
      3'h7: prot_span = 8'h40;
    endcase
  end

  // Protect map per block
  generate
    for (genvar b = 0; b < PFR_NUM_BLOCKS; b++) begin : g_map
      localparam int TOPIDX = PFR_NUM_BLOCKS - 1 - b;
      always_comb begin
        if (prot_reg[3]) begin
          prot_map[b] = 1'h1;
        end else if (func_reg[PFR_BIT_AREA]) begin
          prot_map[b] = (8'(b) < prot_span);
        end else begin
          prot_map[b] = (8'(TOPIDX) < prot_span);
        end
      end
    end
  endgenerate

  assign blk_prot = prot_map[I_TARGET_BLOCK];
  assign pgm_ok = cmd[PFR_CMD_PGM_START] && (op_reg == PFR_OP_NONE) && !blk_prot;
  assign ers_ok = cmd[PFR_CMD_ERS_START] && (op_reg == PFR_OP_NONE) && !blk_prot;
  assign chip_ok = cmd[PFR_CMD_CHIP_ERASE] && (op_reg == PFR_OP_NONE) &&
                   (prot_reg == 4'h0);
  assign info_ok = cmd[PFR_CMD_INFO_PGM] && (op_reg == PFR_OP_NONE) &&
                   !func_reg[PFR_BIT_INFO_ROW_LOCK_0 + I_TARGET_ROW];

  always_comb begin
    func_next = func_reg;
    if (wr_en && I_PADDR[3:0] == PFR_ADDR_FUNC) begin
      func_next = func_reg | (I_PWDATA[7:0] & PFR_OTP_MASK);
    end
    if (cmd[PFR_CMD_SUSPEND] && op_reg == PFR_OP_PGM && !susp_reg) begin
      func_next[PFR_BIT_PROGRAM_PAUSED_FLAG] = 1'h1;
    end else if (cmd[PFR_CMD_RESUME] && op_reg == PFR_OP_PGM) begin
      func_next[PFR_BIT_PROGRAM_PAUSED_FLAG] = 1'h0;
    end
    if (cmd[PFR_CMD_SUSPEND] && op_reg == PFR_OP_ERS && !susp_reg) begin
      func_next[PFR_BIT_ERASE_PAUSED_FLAG] = 1'h1;
    end else if (cmd[PFR_CMD_RESUME] && op_reg == PFR_OP_ERS) begin
      func_next[PFR_BIT_ERASE_PAUSED_FLAG] = 1'h0;
    end
  end

  // Function register, variant default caught after reset release
  always_ff @(posedge I_MCLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      func_reg <= PFR_FUNC_RESET;
      rst_done_reg <= 1'h0;
    end else if (!rst_done_reg) begin
      func_reg <= PFR_FUNC_RESET | {7'h00, RSTDIS_DEFAULT};
      rst_done_reg <= 1'h1;
    end else begin
      func_reg <= func_next;
    end
  end

  always_ff @(posedge I_MCLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      prot_reg <= PFR_PROT_RESET;
    end else if (wr_en && I_PADDR[3:0] == PFR_ADDR_PROT) begin
      prot_reg <= I_PWDATA[3:0];
    end
  end

  // Operation tracker
  always_ff @(posedge I_MCLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      op_reg <= PFR_OP_NONE;
      susp_reg <= 1'h0;
    end else if (pgm_ok || info_ok) begin
      op_reg <= PFR_OP_PGM;
    end else if (ers_ok || chip_ok) begin
      op_reg <= PFR_OP_ERS;
    end else if (cmd[PFR_CMD_SUSPEND] && op_reg != PFR_OP_NONE) begin
      susp_reg <= 1'h1;
    end else if (cmd[PFR_CMD_RESUME]) begin
      susp_reg <= 1'h0;
    end else if (cmd[PFR_CMD_DONE] && !susp_reg) begin
      op_reg <= PFR_OP_NONE;
    end
  end

  always_ff @(posedge I_MCLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      rej_reg <= 1'h0;
    end else if ((cmd[PFR_CMD_PGM_START] && !pgm_ok) || (cmd[PFR_CMD_ERS_START] && !ers_ok) ||
                 (cmd[PFR_CMD_CHIP_ERASE] && !chip_ok) ||
                 (cmd[PFR_CMD_INFO_PGM] && !info_ok)) begin
      rej_reg <= 1'h1;
    end else if (wr_en && I_PADDR[3:0] == PFR_ADDR_STAT) begin
      rej_reg <= 1'h0;
    end
  end

  always_ff @(posedge I_MCLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      rdata_reg <= 32'h0000_0000;
    end else if (rd_en && !I_PENABLE) begin
      unique case (I_PADDR[3:0])
        PFR_ADDR_FUNC: rdata_reg <= {24'h000000, func_reg};
        PFR_ADDR_PROT: rdata_reg <= {28'h0000000, prot_reg};
        PFR_ADDR_STAT: rdata_reg <= {28'h0000000, rej_reg, susp_reg,
                                     op_reg == PFR_OP_ERS, op_reg == PFR_OP_PGM};
        default: rdata_reg <= 32'h0000_0000;
      endcase
    end
  end

  assign O_PRDATA = rdata_reg;
  assign O_RESTART_DEDICATED_EN = !func_reg[PFR_BIT_RSTDIS];
  assign O_RESTART_SHARED_EN = func_reg[PFR_BIT_RSTDIS];
  assign O_OP_PGM_ACTIVE = (op_reg == PFR_OP_PGM) && !susp_reg;
  assign O_OP_ERS_ACTIVE = (op_reg == PFR_OP_ERS) && !susp_reg;
  assign O_CMD_REJECTED = rej_reg;

  a_otp_sticky: assert property (@(posedge I_MCLK) disable iff (!I_RESET_N)
    rst_done_reg && $past(rst_done_reg)
    |-> ($past(func_reg) & PFR_OTP_MASK & ~func_reg) == 8'h00)
    else $error("OTP bit cleared");
  a_chip_guard: assert property (@(posedge I_MCLK) disable iff (!I_RESET_N)
    chip_ok
    |-> prot_reg == 4'h0)
    else $error("Chip erase with protect code set");
  a_prot_inhibit: assert property (@(posedge I_MCLK) disable iff (!I_RESET_N)
    cmd[PFR_CMD_PGM_START] && blk_prot
    |=> op_reg == $past(op_reg))
    else $error("Program started in protected area");
  a_all_protect: assert property (@(posedge I_MCLK) disable iff (!I_RESET_N)
    prot_reg[3]
    |-> &prot_map)
    else $error("Code with MSB set not all blocks");
  a_bottom_one: assert property (@(posedge I_MCLK) disable iff (!I_RESET_N)
    prot_reg == 4'h1 && func_reg[PFR_BIT_AREA]
    |-> prot_map[0] && !prot_map[1])
    else $error("Bottom single block wrong");
  a_top_seven: assert property (@(posedge I_MCLK) disable iff (!I_RESET_N)
    prot_reg == 4'h7 && !func_reg[PFR_BIT_AREA]
    |-> prot_map[64] && !prot_map[63])
    else $error("Top 64 blocks wrong");
  a_program_paused_flag_set: assert property (@(posedge I_MCLK) disable iff (!I_RESET_N)
    rst_done_reg && cmd[PFR_CMD_SUSPEND] && op_reg == PFR_OP_PGM && !susp_reg
    |=> func_reg[PFR_BIT_PROGRAM_PAUSED_FLAG] && susp_reg)
    else $error("Program pause flag not set");
  a_erase_paused_flag_clr: assert property (@(posedge I_MCLK) disable iff (!I_RESET_N)
    rst_done_reg && cmd[PFR_CMD_RESUME] && op_reg == PFR_OP_ERS
    |=> !func_reg[PFR_BIT_ERASE_PAUSED_FLAG])
    else $error("Erase pause flag not cleared");
  a_row_lock: assert property (@(posedge I_MCLK) disable iff (!I_RESET_N)
    info_ok
    |-> !func_reg[PFR_BIT_INFO_ROW_LOCK_0 + I_TARGET_ROW])
    else $error("Locked row programmed");
  a_pin_select: assert property (@(posedge I_MCLK) disable iff (!I_RESET_N)
    O_RESTART_SHARED_EN
    != O_RESTART_DEDICATED_EN)
    else $error("Restart pin select");
  a_none_zero: assert property (@(posedge I_MCLK) disable iff (!I_RESET_N)
    prot_reg == 4'h0
    |-> !(|prot_map))
    else $error("Code zero protects a block");
  a_top_one: assert property (@(posedge I_MCLK) disable iff (!I_RESET_N)
    prot_reg == 4'h1 && !func_reg[PFR_BIT_AREA]
    |-> prot_map[127] && !prot_map[126])
    else $error("Top 1 block wrong");
  a_top_two: assert property (@(posedge I_MCLK) disable iff (!I_RESET_N)
    prot_reg == 4'h2 && !func_reg[PFR_BIT_AREA]
    |-> prot_map[126] && !prot_map[125])
    else $error("Top 2 blocks wrong");
  a_top_three: assert property (@(posedge I_MCLK) disable iff (!I_RESET_N)
    prot_reg == 4'h3 && !func_reg[PFR_BIT_AREA]
    |-> prot_map[124] && !prot_map[123])
    else $error("Top 4 blocks wrong");
  a_top_four: assert property (@(posedge I_MCLK) disable iff (!I_RESET_N)
    prot_reg == 4'h4 && !func_reg[PFR_BIT_AREA]
    |-> prot_map[120] && !prot_map[119])
    else $error("Top 8 blocks wrong");
  a_top_five: assert property (@(posedge I_MCLK) disable iff (!I_RESET_N)
    prot_reg == 4'h5 && !func_reg[PFR_BIT_AREA]
    |-> prot_map[112] && !prot_map[111])
    else $error("Top 16 blocks wrong");
  a_top_six: assert property (@(posedge I_MCLK) disable iff (!I_RESET_N)
    prot_reg == 4'h6 && !func_reg[PFR_BIT_AREA]
    |-> prot_map[96] && !prot_map[95])
    else $error("Top 32 blocks wrong");
  a_bottom_two: assert property (@(posedge I_MCLK) disable iff (!I_RESET_N)
    prot_reg == 4'h2 && func_reg[PFR_BIT_AREA]
    |-> prot_map[1] && !prot_map[2])
    else $error("Bottom 2 blocks wrong");
  a_bottom_three: assert property (@(posedge I_MCLK) disable iff (!I_RESET_N)
    prot_reg == 4'h3 && func_reg[PFR_BIT_AREA]
    |-> prot_map[3] && !prot_map[4])
    else $error("Bottom 4 blocks wrong");
  a_bottom_four: assert property (@(posedge I_MCLK) disable iff (!I_RESET_N)
    prot_reg == 4'h4 && func_reg[PFR_BIT_AREA]
    |-> prot_map[7] && !prot_map[8])
    else $error("Bottom 8 blocks wrong");
  a_bottom_five: assert property (@(posedge I_MCLK) disable iff (!I_RESET_N)
    prot_reg == 4'h5 && func_reg[PFR_BIT_AREA]
    |-> prot_map[15] && !prot_map[16])
    else $error("Bottom 16 blocks wrong");
  a_bottom_six: assert property (@(posedge I_MCLK) disable iff (!I_RESET_N)
    prot_reg == 4'h6 && func_reg[PFR_BIT_AREA]
    |-> prot_map[31] && !prot_map[32])
    else $error("Bottom 32 blocks wrong");
  a_bottom_seven: assert property (@(posedge I_MCLK) disable iff (!I_RESET_N)
    prot_reg == 4'h7 && func_reg[PFR_BIT_AREA]
    |-> prot_map[63] && !prot_map[64])
    else $error("Bottom 64 blocks wrong");
  a_bottom_start: assert property (@(posedge I_MCLK) disable iff (!I_RESET_N)
    prot_reg != 4'h0 && func_reg[PFR_BIT_AREA]
    |-> prot_map[0])
    else $error("Bottom area misses block zero");
  a_area_top: assert property (@(posedge I_MCLK) disable iff (!I_RESET_N)
    !prot_reg[3] && !func_reg[PFR_BIT_AREA]
    |-> !prot_map[0])
    else $error("Top area reaches block zero");
  a_area_bottom: assert property (@(posedge I_MCLK) disable iff (!I_RESET_N)
    !prot_reg[3] && func_reg[PFR_BIT_AREA]
    |-> !prot_map[127])
    else $error("Bottom area reaches last block");
  a_pin_dedicated: assert property (@(posedge I_MCLK) disable iff (!I_RESET_N)
    !func_reg[PFR_BIT_RSTDIS]
    |-> O_RESTART_DEDICATED_EN)
    else $error("Dedicated restart pin off");
  a_reset_value: assert property (@(posedge I_MCLK) disable iff (!I_RESET_N)
    rst_done_reg && !$past(rst_done_reg)
    |-> func_reg == (PFR_FUNC_RESET | {7'h00, RSTDIS_DEFAULT}))
    else $error("Function register default wrong");
  a_program_paused_flag_clr: assert property (@(posedge I_MCLK) disable iff (!I_RESET_N)
    rst_done_reg && cmd[PFR_CMD_RESUME] && op_reg == PFR_OP_PGM
    |=> !func_reg[PFR_BIT_PROGRAM_PAUSED_FLAG])
    else $error("Program pause flag not cleared");
  a_erase_paused_flag_set: assert property (@(posedge I_MCLK) disable iff (!I_RESET_N)
    rst_done_reg && cmd[PFR_CMD_SUSPEND] && op_reg == PFR_OP_ERS && !susp_reg
    |=> func_reg[PFR_BIT_ERASE_PAUSED_FLAG] && susp_reg)
    else $error("Erase pause flag not set");
  a_program_paused_flag_hold: assert property (@(posedge I_MCLK) disable iff (!I_RESET_N)
    rst_done_reg && func_reg[PFR_BIT_PROGRAM_PAUSED_FLAG] && !cmd[PFR_CMD_RESUME]
    |=> func_reg[PFR_BIT_PROGRAM_PAUSED_FLAG])
    else $error("Program pause flag lost");
  a_erase_paused_flag_hold: assert property (@(posedge I_MCLK) disable iff (!I_RESET_N)
    rst_done_reg && func_reg[PFR_BIT_ERASE_PAUSED_FLAG] && !cmd[PFR_CMD_RESUME]
    |=> func_reg[PFR_BIT_ERASE_PAUSED_FLAG])
    else $error("Erase pause flag lost");
  a_row_reject: assert property (@(posedge I_MCLK) disable iff (!I_RESET_N)
    cmd[PFR_CMD_INFO_PGM] && func_reg[PFR_BIT_INFO_ROW_LOCK_0 + I_TARGET_ROW]
    |=> rej_reg)
    else $error("Locked row program not refused");
  a_prot_reject: assert property (@(posedge I_MCLK) disable iff (!I_RESET_N)
    cmd[PFR_CMD_PGM_START] && blk_prot
    |=> rej_reg)
    else $error("Protected program not refused");
  a_erase_inhibit: assert property (@(posedge I_MCLK) disable iff (!I_RESET_N)
    cmd[PFR_CMD_ERS_START] && blk_prot
    |=> rej_reg)
    else $error("Protected erase not refused");
  a_chip_reject: assert property (@(posedge I_MCLK) disable iff (!I_RESET_N)
    cmd[PFR_CMD_CHIP_ERASE] && prot_reg != 4'h0
    |=> rej_reg)
    else $error("Whole array erase not refused");
  a_pause_ignore: assert property (@(posedge I_MCLK) disable iff (!I_RESET_N)
    rst_done_reg && wr_en && I_PADDR[3:0] == PFR_ADDR_FUNC
    |=> func_reg[PFR_BIT_ERASE_PAUSED_FLAG:PFR_BIT_PROGRAM_PAUSED_FLAG] == $past(func_reg[PFR_BIT_ERASE_PAUSED_FLAG:PFR_BIT_PROGRAM_PAUSED_FLAG]))
    else $error("Pause flags took written value");
  a_otp_write: assert property (@(posedge I_MCLK) disable iff (!I_RESET_N)
    rst_done_reg && wr_en && I_PADDR[3:0] == PFR_ADDR_FUNC
    |=> (func_reg & PFR_OTP_MASK) == (($past(func_reg) | $past(I_PWDATA[7:0])) & PFR_OTP_MASK))
    else $error("One-time bits not merged");
  a_prot_write: assert property (@(posedge I_MCLK) disable iff (!I_RESET_N)
    wr_en && I_PADDR[3:0] == PFR_ADDR_PROT
    |=> prot_reg == $past(I_PWDATA[3:0]))
    else $error("Protect code write lost");
  a_pgm_unpaused: assert property (@(posedge I_MCLK) disable iff (!I_RESET_N)
    O_OP_PGM_ACTIVE
    |-> !func_reg[PFR_BIT_PROGRAM_PAUSED_FLAG])
    else $error("Program running while paused");
  a_ers_unpaused: assert property (@(posedge I_MCLK) disable iff (!I_RESET_N)
    O_OP_ERS_ACTIVE
    |-> !func_reg[PFR_BIT_ERASE_PAUSED_FLAG])
    else $error("Erase running while paused");
endmodule

// >>> bench/pfr_host.sv
// Host model driving register bus transfers
`timescale 1ns/100ps
module pfr_host (
  input wire logic i_clk,
  input wire logic i_pready,
  input wire logic i_pslverr,
  input wire logic [31:0] i_prdata,
  output logic o_psel,
  output logic o_penable,
  output logic o_pwrite,
  output logic [31:0] o_paddr,
  output logic [31:0] o_pwdata
);
  int hang = 0;
  logic [31:0] rd;
  logic err;
  initial {o_psel, o_penable, o_pwrite, o_paddr, o_pwdata} = '0;
  task xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
    int k;
    @(posedge i_clk);
    o_psel <= 1'h1;
    o_pwrite <= w;
    o_paddr <= a;
    o_pwdata <= d;
    @(posedge i_clk);
    o_penable <= 1'h1;
    k = 0;
    do begin
      @(posedge i_clk);
      k++;
    end while (i_pready !== 1'h1 && k < 20);
    if (k >= 20) begin
      hang++;
      tb_protect_function_register.complete_run();
    end
    rd = i_prdata;
    err = i_pslverr;
    o_psel <= 1'h0;
    o_penable <= 1'h0;
    o_pwdata <= ~d;
  endtask
endmodule

// >>> bench/tb_protect_function_register.sv
// Testbench for the protect and function register block
`timescale 1ns/100ps
module tb_protect_function_register import pfr_pkg::*;;
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  logic [6:0] blk = 7'h0;
  logic [1:0] row = 2'h0;
  logic psel, penable, pwrite, pready, pslverr, ded, shr, pgm, ers, rej;
  logic [31:0] paddr, pwdata, prdata, w;
  logic [7:0] fm = 8'h0;
  int n_mismatch = 0;
  int tests_run = 0;
  always #50 clk = ~clk;
  pfr_top i_dut (.I_MCLK(clk), .I_RESET_N(rst_n), .I_PSEL(psel), .I_PENABLE(penable),
    .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata),
    .O_PREADY(pready), .O_PSLVERR(pslverr), .I_TARGET_BLOCK(blk), .I_TARGET_ROW(row),
    .O_RESTART_DEDICATED_EN(ded), .O_RESTART_SHARED_EN(shr), .O_OP_PGM_ACTIVE(pgm),
    .O_OP_ERS_ACTIVE(ers), .O_CMD_REJECTED(rej));
  pfr_host i_host (.i_clk(clk), .i_pready(pready), .i_pslverr(pslverr), .i_prdata(prdata),
    .o_psel(psel), .o_penable(penable), .o_pwrite(pwrite), .o_paddr(paddr),
    .o_pwdata(pwdata));
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task rdf(input logic [3:0] a);
    i_host.xfer(1'h0, {28'h0, a}, 32'h0);
  endtask
  task cmd(input int b);
    i_host.xfer(1'h1, {28'h0, PFR_ADDR_CMD}, 32'h1 << b);
  endtask
  task op(input int b, input int code, input logic e);
    i_host.xfer(1'h1, {28'h0, PFR_ADDR_PROT}, code);
    cmd(b);
    rdf(PFR_ADDR_STAT);
    chk("rejected", e, i_host.rd[3]);
    chk("reject pin", e, rej);
    cmd(PFR_CMD_DONE);
    i_host.xfer(1'h1, {28'h0, PFR_ADDR_STAT}, 32'hF);
  endtask
  function automatic logic prot(int c, int ar, int b);
    int n;
    if (c == 0) return 1'h0;
    if (c >= 8) return 1'h1;
    n = 1 << (c - 1);
    return ar ? (b < n) : (b >= PFR_NUM_BLOCKS - n);
  endfunction
  task sweep(input int ar);
    int n;
    int v;
    for (int c = 0; c < 16; c++) begin
      n = (c >= 1 && c <= 7) ? 1 << (c - 1) : $urandom_range(127, 1);
      v = ar ? n - 1 + $urandom_range(1) : 128 - n - $urandom_range(1);
      blk <= 7'(v);
      op(PFR_CMD_PGM_START, c, prot(c, ar, v));
    end
  endtask
  task complete_run;
    n_mismatch += i_host.hang;
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    void'($urandom(88));
    repeat (3) @(posedge clk);
    rst_n <= 1'h1;
    repeat (2) @(posedge clk);
    rdf(PFR_ADDR_FUNC);
    chk("func reset", 32'h0, i_host.rd);
    chk("dedicated", 1'h1, ded);
    sweep(0);
    for (int c = 1; c >= 0; c--) op(PFR_CMD_CHIP_ERASE, c, c);
    for (int k = 0; k < 2; k++) begin
      i_host.xfer(1'h1, {28'h0, PFR_ADDR_FUNC}, 32'hC);
      cmd(k ? PFR_CMD_ERS_START : PFR_CMD_PGM_START);
      @(negedge clk);
      chk("active", k ? 32'h1 : 32'h2, {pgm, ers});
      cmd(PFR_CMD_SUSPEND);
      rdf(PFR_ADDR_FUNC);
      chk("paused", k ? 32'h8 : 32'h4, i_host.rd);
      chk("running", 2'h0, {pgm, ers});
      cmd(PFR_CMD_RESUME);
      rdf(PFR_ADDR_FUNC);
      chk("resumed", 32'h0, i_host.rd);
      cmd(PFR_CMD_DONE);
    end
    w = $urandom | 32'h12;
    fm = w[7:0] & PFR_OTP_MASK;
    i_host.xfer(1'h1, {28'h0, PFR_ADDR_FUNC}, w);
    i_host.xfer(1'h1, {28'h0, PFR_ADDR_FUNC}, 32'h0);
    i_host.xfer(1'h1, 32'h10, 32'hFF);
    chk("slverr", 1'h1, i_host.err);
    rdf(PFR_ADDR_FUNC);
    chk("func otp", {24'h0, fm}, i_host.rd);
    chk("restart pins", {~fm[0], fm[0]}, {ded, shr});
    sweep(1);
    for (int r = 0; r < 4; r++) begin
      row <= 2'(r);
      op(PFR_CMD_INFO_PGM, 0, fm[PFR_BIT_INFO_ROW_LOCK_0 + r]);
    end
    complete_run();
  end
endmodule
